// *** design/branch_shift_flag_unit.sv ***
// Decided for this implementation: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
// How it works
// - carry branches: taken adds offset plus one
// - same-or-higher on carry zero, lower on one
// - signed ge taken when n xor v zero
// - signed lt taken when n xor v one
// - minus on negative one, plus on zero
// - half-carry branches follow the half-carry flag
// - transfer branches follow the transfer flag
// - overflow branches follow the overflow flag
// - irq branches follow the interrupt enable flag
// - io set bit, flags kept, two cycles
// - io clear bit, flags kept, two cycles
// - logical shifts fill zero, update z c n v
// - rotate left: bit0 from carry, carry from bit7
// - rotate right: bit7 from carry, carry from bit0
// - bit store copies register bit into transfer
// - bit load copies transfer into register bit
// - one-cycle set or clear of single flag
// - overflow flag set or clear alone
// - half-carry flag set alone
module branch_shift_flag_unit
  import unit_pkg::*;
(
  // clock, reset, enable
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  // avalon-mm slave
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [DATA_W-1:0] writedata,
  output logic [DATA_W-1:0] readdata,
  output logic waitrequest,
  // core state
  output logic [15:0] program_counter,
  output logic [7:0] status_register,
  output logic busy
);

  state_t state_q;
  bus_t bus_q;
  logic [OP_W-1:0] op_q;
  logic [31:0] operand_q;
  logic [15:0] pc_q;
  logic [7:0] status_q;
  logic [7:0] result_q;
  logic taken_q;
  logic [1:0] cycles_q;
  logic [31:0] readdata_q;
  logic waitreq_q;
  logic busy_q;

  logic [7:0] opd;
  logic [2:0] bit_sel;
  logic [IO_AW-1:0] io_idx;
  logic [OFS_W-1:0] ofs;
  logic [15:0] pc_target;
  logic is_branch;
  logic is_io;
  logic is_shift;
  logic cond_w;
  logic [7:0] sh_res;
  logic sh_c;
  logic [31:0] rd_mux;
  logic [31:0] pc_wr;
  logic acc_wr;
  logic io_hit;
  logic mem_we;
  logic [IO_AW-1:0] mem_waddr;
  logic [7:0] mem_wdata;
  logic [IO_AW-1:0] mem_raddr;
  logic [7:0] mem_rdata;

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  assign opd = operand_q[OPD_REG_LSB +: 8];
  assign bit_sel = operand_q[OPD_BIT_LSB +: 3];
  assign io_idx = operand_q[OPD_IO_LSB +: IO_AW];
  assign ofs = operand_q[OPD_OFS_LSB +: OFS_W];
  assign pc_target = pc_q + {{(16-OFS_W){ofs[OFS_W-1]}}, ofs} + 16'h0001;
  assign is_branch = (op_q[4] == 1'b0);
  assign is_io = (op_q == OP_IO_BIT_SET) || (op_q == OP_IO_BIT_CLEAR);
  assign is_shift = (op_q >= OP_SHIFT_LEFT_LOGICAL) && (op_q <= OP_ROTATE_RIGHT_CARRY);
  assign io_hit = address[IO_WIN_BIT];
  // upper half of the pc word is not stored, so it always reads zero
  assign pc_wr = merge({16'h0000, pc_q}, writedata, byteenable);
  // a write lands only at the edge where the master sees waitrequest low
  assign acc_wr = (bus_q == B_ANSWER) && write;

  // branch condition per operation
  always_comb begin
    cond_w = 1'b0;
    case (op_q)
      OP_BRANCH_CARRY_SET: cond_w = status_q[FLAG_C];
      OP_BRANCH_CARRY_CLEAR: cond_w = !status_q[FLAG_C];
      OP_BRANCH_SAME_OR_HIGHER: cond_w = !status_q[FLAG_C];
      OP_BRANCH_LOWER: cond_w = status_q[FLAG_C];
      OP_BRANCH_MINUS: cond_w = status_q[FLAG_N];
      OP_BRANCH_PLUS: cond_w = !status_q[FLAG_N];
      OP_BRANCH_SIGNED_GE: cond_w = !(status_q[FLAG_N] ^ status_q[FLAG_V]);
      OP_BRANCH_SIGNED_LT: cond_w = status_q[FLAG_N] ^ status_q[FLAG_V];
      OP_BRANCH_HALF_CARRY_SET: cond_w = status_q[FLAG_H];
      OP_BRANCH_HALF_CARRY_CLEAR: cond_w = !status_q[FLAG_H];
      OP_BRANCH_TRANSFER_SET: cond_w = status_q[FLAG_T];
      OP_BRANCH_TRANSFER_CLEAR: cond_w = !status_q[FLAG_T];
      OP_BRANCH_OVERFLOW_SET: cond_w = status_q[FLAG_V];
      OP_BRANCH_OVERFLOW_CLEAR: cond_w = !status_q[FLAG_V];
      OP_BRANCH_IRQ_ENABLED: cond_w = status_q[FLAG_I];
      OP_BRANCH_IRQ_DISABLED: cond_w = !status_q[FLAG_I];
      default: cond_w = 1'b0;
    endcase
  end

  // shifter and bit insert
  always_comb begin
    sh_res = opd;
    sh_c = status_q[FLAG_C];
    case (op_q)
      OP_SHIFT_LEFT_LOGICAL: begin
        sh_res = {opd[6:0], 1'b0};
        sh_c = opd[7];
      end
      OP_SHIFT_RIGHT_LOGICAL: begin
        sh_res = {1'b0, opd[7:1]};
        sh_c = opd[0];
      end
      OP_ROTATE_LEFT_CARRY: begin
        sh_res = {opd[6:0], status_q[FLAG_C]};
        sh_c = opd[7];
      end
      OP_ROTATE_RIGHT_CARRY: begin
        sh_res = {status_q[FLAG_C], opd[7:1]};
        sh_c = opd[0];
      end
      OP_TRANSFER_FLAG_TO_BIT: begin
        sh_res[bit_sel] = status_q[FLAG_T];
      end
      default: begin
        sh_res = opd;
      end
    endcase
  end

  // engine sequencing
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= S_IDLE;
      op_q <= 5'h00;
      busy_q <= 1'b0;
    end else if (ce) begin
      case (state_q)
        S_IDLE: begin
          if (acc_wr && !io_hit && address == CMD_OFS && byteenable[0]) begin
            op_q <= writedata[OP_W-1:0];
            state_q <= S_EXEC;
            busy_q <= 1'b1;
          end
        end
        S_EXEC: begin
          // taken branches and io read-modify-write need a second cycle
          if ((is_branch && cond_w) || is_io) begin
            state_q <= S_SECOND;
          end else begin
            state_q <= S_IDLE;
            busy_q <= 1'b0;
          end
        end
        S_SECOND: begin
          state_q <= S_IDLE;
          busy_q <= 1'b0;
        end
        default: begin
          state_q <= S_IDLE;
          busy_q <= 1'b0;
        end
      endcase
    end
  end

  // program counter
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pc_q <= PC_RST;
    end else if (ce) begin
      if (acc_wr && !io_hit && address == PC_OFS) begin
        pc_q <= pc_wr[15:0];
      end else if (state_q == S_EXEC && is_branch) begin
        pc_q <= cond_w ? pc_target : pc_q + 16'h0001;
      end
    end
  end

  // status flags; shifts leave s, h, t and i alone
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      status_q <= STATUS_RST;
    end else if (ce) begin
      if (acc_wr && !io_hit && address == STATUS_OFS && byteenable[0]) begin
        status_q <= writedata[7:0];
      end else if (state_q == S_EXEC) begin
        if (is_shift) begin
          status_q[FLAG_C] <= sh_c;
          status_q[FLAG_Z] <= (sh_res == 8'h00);
          status_q[FLAG_N] <= sh_res[7];
          status_q[FLAG_V] <= sh_res[7] ^ sh_c;
        end else if (op_q == OP_BIT_TO_TRANSFER_FLAG) begin
          status_q[FLAG_T] <= opd[bit_sel];
        end else if (op_q == OP_FLAG_SET) begin
          status_q[bit_sel] <= 1'b1;
        end else if (op_q == OP_FLAG_CLEAR) begin
          status_q[bit_sel] <= 1'b0;
        end
      end
    end
  end

  // operand and result registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      operand_q <= WORD_RST;
    end else if (ce && acc_wr && !io_hit && address == OPERAND_OFS) begin
      operand_q <= merge(operand_q, writedata, byteenable);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      result_q <= 8'h00;
      taken_q <= 1'b0;
      cycles_q <= 2'h0;
    end else if (ce && state_q == S_EXEC) begin
      result_q <= sh_res;
      taken_q <= is_branch && cond_w;
      cycles_q <= ((is_branch && cond_w) || is_io) ? CYC_TWO : CYC_ONE;
    end
  end

  // io space: bus when idle, engine otherwise
  assign mem_raddr = (state_q == S_IDLE) ? address[2 +: IO_AW] : io_idx;
  always_comb begin
    mem_we = 1'b0;
    mem_waddr = io_idx;
    mem_wdata = mem_rdata;
    if (state_q == S_SECOND && is_io) begin
      mem_we = 1'b1;
      mem_wdata[bit_sel] = (op_q == OP_IO_BIT_SET);
    end else if (acc_wr && io_hit && byteenable[0]) begin
      mem_we = 1'b1;
      mem_waddr = address[2 +: IO_AW];
      mem_wdata = writedata[7:0];
    end
  end

  io_space_ram u_io (
    .clk(clk),
    .arst_n(arst_n),
    .ce(ce),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .raddr(mem_raddr),
    .rdata(mem_rdata)
  );

  // read mux; unmapped offsets read zero
  always_comb begin
    rd_mux = WORD_RST;
    if (io_hit) begin
      rd_mux[7:0] = mem_rdata;
    end else begin
      case (address)
        CMD_OFS: rd_mux[OP_W-1:0] = op_q;
        OPERAND_OFS: rd_mux = operand_q;
        PC_OFS: rd_mux[15:0] = pc_q;
        STATUS_OFS: rd_mux[7:0] = status_q;
        RESULT_OFS: begin
          rd_mux[7:0] = result_q;
          rd_mux[RES_TAKEN_BIT] = taken_q;
          rd_mux[RES_CYC_LSB +: 2] = cycles_q;
        end
        default: rd_mux = WORD_RST;
      endcase
    end
  end

  // bus handshake: fixed three-edge answer, held off while the engine runs
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bus_q <= B_WAIT;
      waitreq_q <= 1'b1;
      readdata_q <= WORD_RST;
    end else if (ce) begin
      case (bus_q)
        B_WAIT: begin
          if ((read || write) && state_q == S_IDLE) begin
            bus_q <= B_FETCH;
          end
        end
        B_FETCH: begin
          readdata_q <= rd_mux;
          waitreq_q <= 1'b0;
          bus_q <= B_ANSWER;
        end
        B_ANSWER: begin
          waitreq_q <= 1'b1;
          bus_q <= B_WAIT;
        end
        default: begin
          waitreq_q <= 1'b1;
          bus_q <= B_WAIT;
        end
      endcase
    end
  end

  assign readdata = readdata_q;
  assign waitrequest = waitreq_q;
  assign program_counter = pc_q;
  assign status_register = status_q;
  assign busy = busy_q;

  default clocking dc @(posedge clk iff ce);
  endclocking
  default disable iff (!arst_n);

  chk_taken_timing: assert property (
    (state_q == S_EXEC && is_branch && cond_w)
      |=> (state_q == S_SECOND) ##1 (state_q == S_IDLE))
    else $error("taken branch did not take two cycles");
  chk_taken_target: assert property (
    (state_q == S_EXEC && is_branch && cond_w)
      |=> pc_q == $past(pc_q) + {{(16-OFS_W){$past(ofs[OFS_W-1])}}, $past(ofs)} + 16'h0001)
    else $error("taken branch target wrong");
  chk_untaken_step: assert property (
    (state_q == S_EXEC && is_branch && !cond_w)
      |=> (state_q == S_IDLE) && (pc_q == $past(pc_q) + 16'h0001))
    else $error("untaken branch not one cycle");
  chk_signed_ge: assert property (
    (state_q == S_EXEC && op_q == OP_BRANCH_SIGNED_GE
      && (status_q[FLAG_N] == status_q[FLAG_V])) |=> state_q == S_SECOND)
    else $error("signed ge not taken");
  chk_signed_lt: assert property (
    (state_q == S_EXEC && op_q == OP_BRANCH_SIGNED_LT
      && (status_q[FLAG_N] == status_q[FLAG_V])) |=> state_q == S_IDLE)
    else $error("signed lt taken wrongly");
  chk_io_set_bit: assert property (
    (state_q == S_EXEC && op_q == OP_IO_BIT_SET)
      |=> mem_we && mem_wdata[bit_sel] && status_q == $past(status_q))
    else $error("io bit set failed");
  chk_io_clear_bit: assert property (
    (state_q == S_EXEC && op_q == OP_IO_BIT_CLEAR)
      |=> mem_we && !mem_wdata[bit_sel] && status_q == $past(status_q))
    else $error("io bit clear failed");
  chk_shift_left: assert property (
    (state_q == S_EXEC && op_q == OP_SHIFT_LEFT_LOGICAL)
      |=> !result_q[0] && status_q[FLAG_C] == $past(opd[7]))
    else $error("logical shift left wrong");
  chk_rotate_left: assert property (
    (state_q == S_EXEC && op_q == OP_ROTATE_LEFT_CARRY)
      |=> result_q[0] == $past(status_q[FLAG_C]) && status_q[FLAG_C] == $past(opd[7]))
    else $error("rotate left wrong");
  chk_rotate_right: assert property (
    (state_q == S_EXEC && op_q == OP_ROTATE_RIGHT_CARRY)
      |=> result_q[7] == $past(status_q[FLAG_C]) && status_q[FLAG_C] == $past(opd[0]))
    else $error("rotate right wrong");
  chk_bit_store: assert property (
    (state_q == S_EXEC && op_q == OP_BIT_TO_TRANSFER_FLAG)
      |=> status_q[FLAG_T] == $past(opd[bit_sel]))
    else $error("bit store wrong");
  chk_bit_load: assert property (
    (state_q == S_EXEC && op_q == OP_TRANSFER_FLAG_TO_BIT)
      |=> result_q[$past(bit_sel)] == status_q[FLAG_T] && status_q == $past(status_q))
    else $error("bit load wrong");
  chk_flag_single: assert property (
    (state_q == S_EXEC && op_q == OP_FLAG_SET)
      |=> status_q == ($past(status_q) | (8'h01 << $past(bit_sel))) && state_q == S_IDLE)
    else $error("flag set touched other flags");

  cov_branch_taken: cover property (state_q == S_EXEC && is_branch && cond_w);
  cov_branch_skip: cover property (state_q == S_EXEC && is_branch && !cond_w);
  cov_io_modify: cover property (state_q == S_SECOND && is_io);
  cov_bus_write: cover property (acc_wr && !io_hit && address == CMD_OFS);

endmodule : branch_shift_flag_unit
`default_nettype wire

// *** design/unit_pkg.sv ***
package unit_pkg;

  // bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // register byte offsets; io space is a window of one word per io byte
  localparam logic [7:0] CMD_OFS = 8'h00;
  localparam logic [7:0] OPERAND_OFS = 8'h04;
  localparam logic [7:0] PC_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0c;
  localparam logic [7:0] RESULT_OFS = 8'h10;
  localparam int IO_WIN_BIT = 7;
  localparam int IO_DEPTH = 32;
  localparam int IO_AW = 5;

  // status register bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;

  // operand register fields
  localparam int OPD_REG_LSB = 0;
  localparam int OPD_BIT_LSB = 8;
  localparam int OPD_IO_LSB = 16;
  localparam int OPD_OFS_LSB = 24;
  localparam int OFS_W = 7;

  // result register fields
  localparam int RES_TAKEN_BIT = 8;
  localparam int RES_CYC_LSB = 12;

  // command field
  localparam int OP_W = 5;

  // reset values
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;

  // cycle counts
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;

  // operation codes
  localparam logic [4:0] OP_BRANCH_CARRY_SET = 5'h00;
  localparam logic [4:0] OP_BRANCH_CARRY_CLEAR = 5'h01;
  localparam logic [4:0] OP_BRANCH_SAME_OR_HIGHER = 5'h02;
  localparam logic [4:0] OP_BRANCH_LOWER = 5'h03;
  localparam logic [4:0] OP_BRANCH_MINUS = 5'h04;
  localparam logic [4:0] OP_BRANCH_PLUS = 5'h05;
  localparam logic [4:0] OP_BRANCH_SIGNED_GE = 5'h06;
  localparam logic [4:0] OP_BRANCH_SIGNED_LT = 5'h07;
  localparam logic [4:0] OP_BRANCH_HALF_CARRY_SET = 5'h08;
  localparam logic [4:0] OP_BRANCH_HALF_CARRY_CLEAR = 5'h09;
  localparam logic [4:0] OP_BRANCH_TRANSFER_SET = 5'h0a;
  localparam logic [4:0] OP_BRANCH_TRANSFER_CLEAR = 5'h0b;
  localparam logic [4:0] OP_BRANCH_OVERFLOW_SET = 5'h0c;
  localparam logic [4:0] OP_BRANCH_OVERFLOW_CLEAR = 5'h0d;
  localparam logic [4:0] OP_BRANCH_IRQ_ENABLED = 5'h0e;
  localparam logic [4:0] OP_BRANCH_IRQ_DISABLED = 5'h0f;
  localparam logic [4:0] OP_IO_BIT_SET = 5'h10;
  localparam logic [4:0] OP_IO_BIT_CLEAR = 5'h11;
  localparam logic [4:0] OP_SHIFT_LEFT_LOGICAL = 5'h12;
  localparam logic [4:0] OP_SHIFT_RIGHT_LOGICAL = 5'h13;
  localparam logic [4:0] OP_ROTATE_LEFT_CARRY = 5'h14;
  localparam logic [4:0] OP_ROTATE_RIGHT_CARRY = 5'h15;
  localparam logic [4:0] OP_BIT_TO_TRANSFER_FLAG = 5'h16;
  localparam logic [4:0] OP_TRANSFER_FLAG_TO_BIT = 5'h17;
  localparam logic [4:0] OP_FLAG_SET = 5'h18;
  localparam logic [4:0] OP_FLAG_CLEAR = 5'h19;

  typedef enum logic [1:0] {S_IDLE, S_EXEC, S_SECOND} state_t;
  typedef enum logic [1:0] {B_WAIT, B_FETCH, B_ANSWER} bus_t;

endpackage : unit_pkg

// *** design/io_space_ram.sv ***
`timescale 1ns/1ns
`default_nettype none
module io_space_ram
  import unit_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  // write port
  input wire logic we,
  input wire logic [IO_AW-1:0] waddr,
  input wire logic [7:0] wdata,
  // read port, data one cycle after the address
  input wire logic [IO_AW-1:0] raddr,
  output logic [7:0] rdata
);

  logic [7:0] mem_q [IO_DEPTH];
  logic [7:0] rdata_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < IO_DEPTH; i++) begin
        mem_q[i] <= 8'h00;
      end
    end else if (ce && we) begin
      mem_q[waddr] <= wdata;
    end
  end

  // read before write on the same address returns the old byte
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= 8'h00;
    end else if (ce) begin
      rdata_q <= mem_q[raddr];
    end
  end

  assign rdata = rdata_q;

endmodule : io_space_ram
`default_nettype wire

// *** verif/core_side.sv ***
`timescale 1ns/1ns
`default_nettype none
module core_side
  import unit_pkg::*;
(
  // clock
  input wire logic clk,
  // avalon-mm master side
  output logic [ADDR_W-1:0] address,
  output logic read,
  output logic write,
  output logic [3:0] byteenable,
  output logic [DATA_W-1:0] writedata,
  input wire logic [DATA_W-1:0] readdata,
  input wire logic waitrequest
);
  int lost = 0;

  initial begin
    address = '0;
    read = 1'b0;
    write = 1'b0;
    byteenable = 4'h0;
    writedata = '0;
  end

  // one edge always passes first, so a request is never driven twice in one step
  task automatic access(input logic wr, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q);
    int n;
    n = 0;
    @(posedge clk);
    address <= a;
    read <= ~wr;
    write <= wr;
    byteenable <= 4'hf;
    writedata <= wr ? d : ~d;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 2000);
    if (waitrequest !== 1'b0) begin
      lost++;
    end
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    byteenable <= 4'h0;
    // released lines change, so a stale value cannot pass for a live one
    address <= ~a;
    writedata <= ~d;
  endtask : access
endmodule : core_side
`default_nettype wire

// *** verif/tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import unit_pkg::*;
;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic ce = 1'b1;
  logic [ADDR_W-1:0] address;
  logic read;
  logic write;
  logic [3:0] byteenable;
  logic [DATA_W-1:0] writedata;
  logic [DATA_W-1:0] readdata;
  logic waitrequest;
  logic [15:0] program_counter;
  logic [7:0] status_register;
  logic busy;
  logic [31:0] res;
  logic [31:0] seed = 32'h943e_613d;
  int num_errors = 0;
  int n_checks = 0;
  int busy_cnt = 0;

  always #25 clk = ~clk;

  // busy length is the cycle count seen from outside
  always @(posedge clk) begin
    if (busy === 1'b1) begin
      busy_cnt++;
    end
  end

  branch_shift_flag_unit dut (
    .clk(clk),
    .arst_n(arst_n),
    .ce(ce),
    .address(address),
    .read(read),
    .write(write),
    .byteenable(byteenable),
    .writedata(writedata),
    .readdata(readdata),
    .waitrequest(waitrequest),
    .program_counter(program_counter),
    .status_register(status_register),
    .busy(busy)
  );

  core_side core (
    .clk(clk),
    .address(address),
    .read(read),
    .write(write),
    .byteenable(byteenable),
    .writedata(writedata),
    .readdata(readdata),
    .waitrequest(waitrequest)
  );

  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction : rnd

  function automatic logic take(input logic [4:0] op, input logic [7:0] s);
    logic f;
    case (op[3:1])
      3'h0: f = s[FLAG_C];
      3'h1: f = ~s[FLAG_C];
      3'h2: f = s[FLAG_N];
      3'h3: f = ~(s[FLAG_N] ^ s[FLAG_V]);
      3'h4: f = s[FLAG_H];
      3'h5: f = s[FLAG_T];
      3'h6: f = s[FLAG_V];
      default: f = s[FLAG_I];
    endcase
    return op[0] ? ~f : f;
  endfunction : take

  function automatic logic [15:0] shift_exp(input logic [4:0] op, input logic [7:0] r,
                                            input logic [7:0] s);
    logic [7:0] y;
    logic c;
    case (op)
      OP_SHIFT_LEFT_LOGICAL: {c, y} = {r, 1'b0};
      OP_SHIFT_RIGHT_LOGICAL: {y, c} = {1'b0, r};
      OP_ROTATE_LEFT_CARRY: {c, y} = {r, s[FLAG_C]};
      default: {y, c} = {s[FLAG_C], r};
    endcase
    s[FLAG_C] = c;
    s[FLAG_Z] = (y == 8'h00);
    s[FLAG_N] = y[7];
    s[FLAG_V] = y[7] ^ c;
    return {s, y};
  endfunction : shift_exp

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic close_out();
    num_errors += core.lost;
    $display("checks=%0d errors=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : close_out

  task automatic run_op(input logic [4:0] op, input logic [31:0] opd, input logic [7:0] st,
                        input logic [15:0] pc);
    logic [31:0] q;
    core.access(1'b1, STATUS_OFS, 32'(st), q);
    core.access(1'b1, PC_OFS, 32'(pc), q);
    core.access(1'b1, OPERAND_OFS, opd, q);
    busy_cnt = 0;
    core.access(1'b1, CMD_OFS, 32'(op), q);
    // held off by the bus until the op is over
    core.access(1'b0, RESULT_OFS, 32'h0000_0000, res);
  endtask : run_op

  task automatic expect_op(input logic [7:0] st_e, input logic tk, input logic [1:0] cyc);
    chk(32'(status_register), 32'(st_e));
    chk(32'(res[RES_TAKEN_BIT]), 32'(tk));
    chk(32'(res[RES_CYC_LSB +: 2]), 32'(cyc));
    chk(32'(busy_cnt), 32'(cyc));
  endtask : expect_op

  initial begin
    repeat (100000) @(posedge clk);
    num_errors++;
    close_out();
  end

  initial begin
    logic [4:0] op;
    logic [7:0] st;
    logic [7:0] r;
    logic [6:0] k;
    logic [15:0] pc;
    logic [2:0] b;
    logic [4:0] n;
    logic [31:0] q;
    logic tk;
    logic [7:0] e;
    logic [15:0] pe;
    repeat (16) @(posedge clk);
    chk(32'(program_counter), 32'(PC_RST));
    chk(32'(status_register), 32'(STATUS_RST));
    chk(32'(waitrequest), 32'h0000_0001);
    arst_n <= 1'b1;
    for (int i = 0; i < 64; i++) begin
      op = 5'(i % 16);
      st = (i < 32) ? 8'(rnd()) : (i < 48) ? 8'h00 : 8'hff;
      k = (i < 16) ? 7'h40 : (i < 24) ? 7'h3f : 7'(rnd());
      pc = (i < 16) ? 16'h0000 : (i < 24) ? 16'hffff : 16'(rnd());
      tk = take(op, st);
      run_op(op, 32'(k) << OPD_OFS_LSB, st, pc);
      e = tk ? 8'h02 : 8'h01;
      // 16-bit sum first: the pc wraps, a 32-bit sum would not
      pe = pc + (tk ? {{9{k[6]}}, k} : 16'h0000) + 16'h0001;
      chk(32'(program_counter), 32'(pe));
      expect_op(st, tk, e[1:0]);
    end
    for (int i = 0; i < 32; i++) begin
      op = OP_SHIFT_LEFT_LOGICAL + 5'(i % 4);
      r = (i < 4) ? 8'h00 : (i < 8) ? 8'h81 : 8'(rnd());
      st = 8'(rnd());
      run_op(op, 32'(r), st, 16'h0000);
      q = 32'(shift_exp(op, r, st));
      expect_op(q[15:8], 1'b0, CYC_ONE);
      chk(32'(res[7:0]), 32'(q[7:0]));
    end
    for (int i = 0; i < 16; i++) begin
      op = (i < 8) ? OP_BIT_TO_TRANSFER_FLAG : OP_TRANSFER_FLAG_TO_BIT;
      b = 3'(i);
      r = 8'(rnd());
      st = 8'(rnd());
      run_op(op, 32'(r) | (32'(b) << OPD_BIT_LSB), st, 16'h0000);
      e = st;
      e[FLAG_T] = op[0] ? st[FLAG_T] : r[b];
      expect_op(e, 1'b0, CYC_ONE);
      r[b] = st[FLAG_T];
      if (op[0]) begin
        chk(32'(res[7:0]), 32'(r));
      end
    end
    for (int i = 0; i < 16; i++) begin
      op = (i < 8) ? OP_FLAG_SET : OP_FLAG_CLEAR;
      b = 3'(i);
      st = 8'(rnd());
      run_op(op, 32'(b) << OPD_BIT_LSB, st, 16'h0000);
      e = st;
      e[b] = ~op[0];
      expect_op(e, 1'b0, CYC_ONE);
    end
    for (int i = 0; i < 8; i++) begin
      op = i[0] ? OP_IO_BIT_CLEAR : OP_IO_BIT_SET;
      n = (i < 2) ? 5'h00 : (i < 4) ? 5'h1f : 5'(rnd());
      b = 3'(rnd());
      r = 8'(rnd());
      st = 8'(rnd());
      core.access(1'b1, 8'h80 + 8'({n, 2'b00}), 32'(r), q);
      run_op(op, (32'(n) << OPD_IO_LSB) | (32'(b) << OPD_BIT_LSB), st, 16'h0000);
      expect_op(st, 1'b0, CYC_TWO);
      core.access(1'b0, 8'h80 + 8'({n, 2'b00}), 32'h0000_0000, q);
      r[b] = ~op[0];
      chk(q, 32'(r));
    end
    st = 8'(rnd());
    run_op(5'h1a, 32'h0000_0000, st, 16'h0000);
    expect_op(st, 1'b0, CYC_ONE);
    core.access(1'b0, 8'h40, 32'h0000_0000, q);
    chk(q, 32'h0000_0000);
    close_out();
  end
endmodule : tb_top
`default_nettype wire
